/* pkg/aod_pkg.sv */
// shared constants and types of the arithmetic opcode decoder
package aod_pkg;
	localparam int AOD_CLK_W = 6;
	localparam int AOD_LEN_W = 3;
	localparam int AOD_W_BIT = 0;
	localparam int AOD_DS_BIT = 1;
	localparam int AOD_MOD_LSB = 6;
	localparam int AOD_REG_LSB = 3;
	localparam int AOD_RM_LSB = 0;

	typedef enum logic [2:0] {
		aod_st_opcode = 3'b000,
		aod_st_modrm = 3'b001,
		aod_st_disp_lo = 3'b011,
		aod_st_disp_hi = 3'b010,
		aod_st_imm_lo = 3'b110,
		aod_st_imm_hi = 3'b111,
		aod_st_finish = 3'b101,
		aod_st_emit = 3'b100
	} aod_state_t;

	typedef enum logic [3:0] {
		aod_op_other,
		aod_op_segment_override,
		aod_op_addition,
		aod_op_add_with_carry,
		aod_op_subtraction,
		aod_op_subtraction_with_borrow,
		aod_op_comparison,
		aod_op_twos_complement_negation,
		aod_op_increment_op,
		aod_op_decrement_op,
		aod_op_unsigned_multiply,
		aod_op_unpacked_bcd_adjust_after_addition,
		aod_op_packed_decimal_adjust_after_addition,
		aod_op_unpacked_bcd_adjust_after_subtraction,
		aod_op_packed_decimal_adjust_after_subtraction
	} aod_op_t;

	typedef enum logic [2:0] {
		aod_form_other, aod_form_prefix, aod_form_rm_reg, aod_form_rm_imm,
		aod_form_acc_imm, aod_form_rm_only, aod_form_short_reg, aod_form_single
	} aod_form_t;

	typedef enum logic [1:0] {aod_grp_none, aod_grp_imm, aod_grp_unary, aod_grp_step} aod_grp_t;
	typedef enum logic [2:0] {
		aod_seg_none, aod_seg_code, aod_seg_stack, aod_seg_data, aod_seg_extra
	} aod_seg_t;

	typedef struct packed {
		logic [AOD_CLK_W-1:0] lo;
		logic [AOD_CLK_W-1:0] hi;
	} aod_clk_t;

	// first-byte patterns, ? marks d, s, w or register bits
	localparam logic [7:0] AOD_PFX_CODE = 8'b0010_1110;
	localparam logic [7:0] AOD_PFX_STACK = 8'b0011_0110;
	localparam logic [7:0] AOD_PFX_DATA = 8'b0011_1110;
	localparam logic [7:0] AOD_PFX_EXTRA = 8'b0010_0110;
	localparam logic [7:0] AOD_OPC_ADD_RM = 8'b0000_00??;
	localparam logic [7:0] AOD_OPC_ADD_ACC = 8'b0000_010?;
	localparam logic [7:0] AOD_OPC_ADC_RM = 8'b0001_00??;
	localparam logic [7:0] AOD_OPC_ADC_ACC = 8'b0001_010?;
	localparam logic [7:0] AOD_OPC_SUB_RM = 8'b0010_10??;
	localparam logic [7:0] AOD_OPC_SUB_ACC = 8'b0010_110?;
	localparam logic [7:0] AOD_OPC_SWB_RM = 8'b0001_10??;
	localparam logic [7:0] AOD_OPC_SWB_ACC = 8'b0001_110?;
	localparam logic [7:0] AOD_OPC_CPR_RM = 8'b0011_10??;
	localparam logic [7:0] AOD_OPC_CPR_ACC = 8'b0011_110?;
	localparam logic [7:0] AOD_OPC_GRP_IMM = 8'b1000_00??;
	localparam logic [7:0] AOD_OPC_GRP_UNARY = 8'b1111_011?;
	localparam logic [7:0] AOD_OPC_GRP_STEP = 8'b1111_111?;
	localparam logic [7:0] AOD_OPC_INC_REG = 8'b0100_0???;
	localparam logic [7:0] AOD_OPC_DCR_REG = 8'b0100_1???;
	localparam logic [7:0] AOD_OPC_UBCD_ADD = 8'b0011_0111;
	localparam logic [7:0] AOD_OPC_PDEC_ADD = 8'b0010_0111;
	localparam logic [7:0] AOD_OPC_UBCD_SUB = 8'b0011_1111;
	localparam logic [7:0] AOD_OPC_PDEC_SUB = 8'b0010_1111;

	// reg field sub-opcodes
	localparam logic [2:0] AOD_SUB_ADD = 3'h0;
	localparam logic [2:0] AOD_SUB_ADC = 3'h2;
	localparam logic [2:0] AOD_SUB_SUB = 3'h5;
	localparam logic [2:0] AOD_SUB_SWB = 3'h3;
	localparam logic [2:0] AOD_SUB_CPR = 3'h7;
	localparam logic [2:0] AOD_SUB_NEGATE = 3'h3;
	localparam logic [2:0] AOD_SUB_MULTIPLY = 3'h4;
	localparam logic [2:0] AOD_SUB_INC = 3'h0;
	localparam logic [2:0] AOD_SUB_DCR = 3'h1;

	localparam logic [1:0] AOD_MOD_NODISP = 2'h0;
	localparam logic [1:0] AOD_MOD_DISP8 = 2'h1;
	localparam logic [1:0] AOD_MOD_DISP16 = 2'h2;
	localparam logic [1:0] AOD_MOD_REG = 2'h3;
	localparam logic [2:0] AOD_RM_DIRECT = 3'h6;

	// execution clocks
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_SEG = 6'h02;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_ALU_REG = 6'h03;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_ALU_MEM = 6'h0A;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_IMM_REG = 6'h04;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_IMM_MEM = 6'h10;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_CPRI_REG = 6'h03;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_CPRI_MEM = 6'h0A;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_ACC_BYTE = 6'h03;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_ACC_WORD = 6'h04;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_NEG_REG = 6'h03;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_NEG_MEM = 6'h0A;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_STEP_REG = 6'h03;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_STEP_MEM = 6'h0F;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_UBCD_ADD = 6'h08;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_PDEC_ADD = 6'h04;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_UBCD_SUB = 6'h07;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_PDEC_SUB = 6'h04;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_MULT_RB_LO = 6'h1A;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_MULT_RB_HI = 6'h1C;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_MULT_RW_LO = 6'h23;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_MULT_RW_HI = 6'h25;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_MULT_MB_LO = 6'h20;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_MULT_MB_HI = 6'h22;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_MULT_MW_LO = 6'h29;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_MULT_MW_HI = 6'h2B;
	localparam logic [AOD_CLK_W-1:0] AOD_CLK_NARROW_EXTRA = 6'h04;
endpackage

/* pkg/aod_class_if.sv */
// carrier between the decoder and its first-byte classifier
`timescale 1ns/1ps
interface aod_class_if;
	import aod_pkg::*;
	logic [7:0] opcode;
	aod_form_t form;
	aod_op_t op;
	aod_grp_t grp;
	aod_seg_t seg;
	modport classifier(input opcode, output form, op, grp, seg);
	modport decoder(output opcode, input form, op, grp, seg);
endinterface

/* src/aod_byte_class.sv */
// first-byte classifier of the arithmetic opcode decoder
`timescale 1ns/1ps
module aod_byte_class (
	// classification carrier
	aod_class_if.classifier cls
);
	import aod_pkg::*;

	always_comb begin
		cls.form = aod_form_other;
		cls.op = aod_op_other;
		cls.grp = aod_grp_none;
		cls.seg = aod_seg_none;
		casez (cls.opcode)
			AOD_PFX_CODE, AOD_PFX_STACK, AOD_PFX_DATA, AOD_PFX_EXTRA: begin
				cls.form = aod_form_prefix;
				cls.op = aod_op_segment_override;
				if (cls.opcode == AOD_PFX_CODE) begin
					cls.seg = aod_seg_code;
				end else if (cls.opcode == AOD_PFX_STACK) begin
					cls.seg = aod_seg_stack;
				end else if (cls.opcode == AOD_PFX_DATA) begin
					cls.seg = aod_seg_data;
				end else begin
					cls.seg = aod_seg_extra;
				end
			end
			AOD_OPC_ADD_RM: begin
				cls.form = aod_form_rm_reg;
				cls.op = aod_op_addition;
			end
			AOD_OPC_ADD_ACC: begin
				cls.form = aod_form_acc_imm;
				cls.op = aod_op_addition;
			end
			AOD_OPC_ADC_RM: begin
				cls.form = aod_form_rm_reg;
				cls.op = aod_op_add_with_carry;
			end
			AOD_OPC_ADC_ACC: begin
				cls.form = aod_form_acc_imm;
				cls.op = aod_op_add_with_carry;
			end
			AOD_OPC_SUB_RM: begin
				cls.form = aod_form_rm_reg;
				cls.op = aod_op_subtraction;
			end
			AOD_OPC_SUB_ACC: begin
				cls.form = aod_form_acc_imm;
				cls.op = aod_op_subtraction;
			end
			AOD_OPC_SWB_RM: begin
				cls.form = aod_form_rm_reg;
				cls.op = aod_op_subtraction_with_borrow;
			end
			AOD_OPC_SWB_ACC: begin
				cls.form = aod_form_acc_imm;
				cls.op = aod_op_subtraction_with_borrow;
			end
			AOD_OPC_CPR_RM: begin
				cls.form = aod_form_rm_reg;
				cls.op = aod_op_comparison;
			end
			AOD_OPC_CPR_ACC: begin
				cls.form = aod_form_acc_imm;
				cls.op = aod_op_comparison;
			end
			AOD_OPC_GRP_IMM: begin
				cls.form = aod_form_rm_imm;
				cls.grp = aod_grp_imm;
			end
			AOD_OPC_GRP_UNARY: begin
				cls.form = aod_form_rm_only;
				cls.grp = aod_grp_unary;
			end
			AOD_OPC_GRP_STEP: begin
				cls.form = aod_form_rm_only;
				cls.grp = aod_grp_step;
			end
			AOD_OPC_INC_REG: begin
				cls.form = aod_form_short_reg;
				cls.op = aod_op_increment_op;
			end
			AOD_OPC_DCR_REG: begin
				cls.form = aod_form_short_reg;
				cls.op = aod_op_decrement_op;
			end
			AOD_OPC_UBCD_ADD: begin
				cls.form = aod_form_single;
				cls.op = aod_op_unpacked_bcd_adjust_after_addition;
			end
			AOD_OPC_PDEC_ADD: begin
				cls.form = aod_form_single;
				cls.op = aod_op_packed_decimal_adjust_after_addition;
			end
			AOD_OPC_UBCD_SUB: begin
				cls.form = aod_form_single;
				cls.op = aod_op_unpacked_bcd_adjust_after_subtraction;
			end
			AOD_OPC_PDEC_SUB: begin
				cls.form = aod_form_single;
				cls.op = aod_op_packed_decimal_adjust_after_subtraction;
			end
			default: cls.form = aod_form_other;
		endcase
	end
endmodule

/* src/aod_decoder.sv */
// arithmetic opcode decoder between prefetch queue and execution unit
`timescale 1ns/1ps
module aod_decoder (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// bus variant
	input wire logic narrow_bus,
	// prefetch queue side
	input wire logic [7:0] q_byte,
	input wire logic q_valid,
	output logic q_ready,
	// execution unit side
	output logic dec_valid,
	input wire logic dec_ready,
	output aod_pkg::aod_op_t dec_op,
	output aod_pkg::aod_form_t dec_form,
	output aod_pkg::aod_seg_t dec_seg,
	output logic dec_w,
	output logic dec_d,
	output logic dec_s,
	output logic [1:0] dec_mod,
	output logic [2:0] dec_reg,
	output logic [2:0] dec_rm,
	output logic dec_mem,
	output logic [15:0] dec_disp,
	output logic [15:0] dec_imm,
	output logic [aod_pkg::AOD_LEN_W-1:0] dec_len,
	output logic [aod_pkg::AOD_CLK_W-1:0] dec_clk_min,
	output logic [aod_pkg::AOD_CLK_W-1:0] dec_clk_max,
	output logic dec_unsupported
);
	import aod_pkg::*;

	aod_class_if cls ();
	aod_state_t state;
	aod_state_t next_state;
	aod_grp_t grp_r;
	aod_seg_t seg_hold;
	aod_clk_t next_clk;
	logic take;
	logic disp_two;
	logic imm_two;
	logic has_imm;
	logic [1:0] in_mod;
	logic [2:0] in_reg;
	logic [2:0] in_rm;
	logic in_disp;

	aod_byte_class u_class (
		.cls(cls)
	);

	assign cls.opcode = q_byte;
	assign in_mod = q_byte[AOD_MOD_LSB +: 2];
	assign in_reg = q_byte[AOD_REG_LSB +: 3];
	assign in_rm = q_byte[AOD_RM_LSB +: 3];
	// stalls while a finished descriptor waits for the execution unit
	assign q_ready = (state != aod_st_finish) && (state != aod_st_emit);
	assign dec_valid = (state == aod_st_emit);
	assign take = q_valid && q_ready;
	assign has_imm = (dec_form == aod_form_rm_imm) || (dec_form == aod_form_acc_imm);
	// accumulator forms take the high byte for any word; group forms only for s w 01
	assign imm_two = (dec_form == aod_form_acc_imm) ? dec_w : (!dec_s && dec_w);
	assign in_disp = (in_mod == AOD_MOD_DISP8) || (in_mod == AOD_MOD_DISP16) ||
		((in_mod == AOD_MOD_NODISP) && (in_rm == AOD_RM_DIRECT));

	function automatic aod_op_t group_op(input aod_grp_t g, input logic [2:0] r, input aod_op_t base);
		aod_op_t o;
		o = base;
		case (g)
			aod_grp_imm: begin
				case (r)
					AOD_SUB_ADD: o = aod_op_addition;
					AOD_SUB_ADC: o = aod_op_add_with_carry;
					AOD_SUB_SUB: o = aod_op_subtraction;
					AOD_SUB_SWB: o = aod_op_subtraction_with_borrow;
					AOD_SUB_CPR: o = aod_op_comparison;
					default: o = aod_op_other;
				endcase
			end
			aod_grp_unary: begin
				case (r)
					AOD_SUB_NEGATE: o = aod_op_twos_complement_negation;
					AOD_SUB_MULTIPLY: o = aod_op_unsigned_multiply;
					default: o = aod_op_other;
				endcase
			end
			aod_grp_step: begin
				case (r)
					AOD_SUB_INC: o = aod_op_increment_op;
					AOD_SUB_DCR: o = aod_op_decrement_op;
					default: o = aod_op_other;
				endcase
			end
			default: o = base;
		endcase
		return o;
	endfunction

	function automatic aod_clk_t cycle_count(input aod_op_t op, input aod_form_t form,
		input logic w, input logic mem, input logic narrow);
		aod_clk_t c;
		logic starred;
		c.lo = '0;
		c.hi = '0;
		starred = 1'b0;
		case (form)
			aod_form_prefix: begin
				c.lo = AOD_CLK_SEG;
				c.hi = AOD_CLK_SEG;
			end
			aod_form_rm_reg: begin
				c.lo = mem ? AOD_CLK_ALU_MEM : AOD_CLK_ALU_REG;
				c.hi = c.lo;
				starred = 1'b1;
			end
			aod_form_rm_imm: begin
				if (op == aod_op_comparison) begin
					c.lo = mem ? AOD_CLK_CPRI_MEM : AOD_CLK_CPRI_REG;
				end else begin
					c.lo = mem ? AOD_CLK_IMM_MEM : AOD_CLK_IMM_REG;
				end
				c.hi = c.lo;
				starred = 1'b1;
			end
			aod_form_acc_imm: begin
				c.lo = w ? AOD_CLK_ACC_WORD : AOD_CLK_ACC_BYTE;
				c.hi = c.lo;
			end
			aod_form_short_reg: begin
				c.lo = AOD_CLK_STEP_REG;
				c.hi = c.lo;
			end
			aod_form_single: begin
				case (op)
					aod_op_unpacked_bcd_adjust_after_addition: c.lo = AOD_CLK_UBCD_ADD;
					aod_op_packed_decimal_adjust_after_addition: c.lo = AOD_CLK_PDEC_ADD;
					aod_op_unpacked_bcd_adjust_after_subtraction: c.lo = AOD_CLK_UBCD_SUB;
					aod_op_packed_decimal_adjust_after_subtraction: c.lo = AOD_CLK_PDEC_SUB;
					default: c.lo = '0;
				endcase
				c.hi = c.lo;
			end
			aod_form_rm_only: begin
				case (op)
					aod_op_twos_complement_negation: begin
						c.lo = mem ? AOD_CLK_NEG_MEM : AOD_CLK_NEG_REG;
						c.hi = c.lo;
						starred = 1'b1;
					end
					aod_op_increment_op, aod_op_decrement_op: begin
						c.lo = mem ? AOD_CLK_STEP_MEM : AOD_CLK_STEP_REG;
						c.hi = c.lo;
						starred = 1'b1;
					end
					aod_op_unsigned_multiply: begin
						// word memory figure is already a word count, no narrow penalty
						case ({mem, w})
							2'h0: c = '{lo: AOD_CLK_MULT_RB_LO, hi: AOD_CLK_MULT_RB_HI};
							2'h1: c = '{lo: AOD_CLK_MULT_RW_LO, hi: AOD_CLK_MULT_RW_HI};
							2'h2: c = '{lo: AOD_CLK_MULT_MB_LO, hi: AOD_CLK_MULT_MB_HI};
							default: c = '{lo: AOD_CLK_MULT_MW_LO, hi: AOD_CLK_MULT_MW_HI};
						endcase
					end
					default: c = '0;
				endcase
			end
			default: c = '0;
		endcase
		if (starred && mem && w && narrow) begin
			c.lo = c.lo + AOD_CLK_NARROW_EXTRA;
			c.hi = c.hi + AOD_CLK_NARROW_EXTRA;
		end
		return c;
	endfunction

	assign next_clk = cycle_count(dec_op, dec_form, dec_w, dec_mem, narrow_bus);

	always_comb begin
		next_state = state;
		case (state)
			aod_st_opcode: begin
				if (take) begin
					case (cls.form)
						aod_form_rm_reg, aod_form_rm_imm, aod_form_rm_only: next_state = aod_st_modrm;
						aod_form_acc_imm: next_state = aod_st_imm_lo;
						default: next_state = aod_st_finish;
					endcase
				end
			end
			aod_st_modrm: begin
				if (take) begin
					if (in_disp) begin
						next_state = aod_st_disp_lo;
					end else if (has_imm) begin
						next_state = aod_st_imm_lo;
					end else begin
						next_state = aod_st_finish;
					end
				end
			end
			aod_st_disp_lo: begin
				if (take) begin
					if (disp_two) begin
						next_state = aod_st_disp_hi;
					end else if (has_imm) begin
						next_state = aod_st_imm_lo;
					end else begin
						next_state = aod_st_finish;
					end
				end
			end
			aod_st_disp_hi: begin
				if (take) begin
					next_state = has_imm ? aod_st_imm_lo : aod_st_finish;
				end
			end
			aod_st_imm_lo: begin
				if (take) begin
					next_state = imm_two ? aod_st_imm_hi : aod_st_finish;
				end
			end
			aod_st_imm_hi: begin
				if (take) begin
					next_state = aod_st_finish;
				end
			end
			aod_st_finish: next_state = aod_st_emit;
			aod_st_emit: begin
				if (dec_ready) begin
					next_state = aod_st_opcode;
				end
			end
			default: next_state = aod_st_opcode;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= aod_st_opcode;
		end else begin
			state <= next_state;
		end
	end

	// first byte and mod r/m fields
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dec_op <= aod_op_other;
			dec_form <= aod_form_other;
			grp_r <= aod_grp_none;
			dec_w <= 1'b0;
			dec_d <= 1'b0;
			dec_s <= 1'b0;
			dec_mod <= 2'h0;
			dec_reg <= 3'h0;
			dec_rm <= 3'h0;
			dec_mem <= 1'b0;
			disp_two <= 1'b0;
		end else if (take && (state == aod_st_opcode)) begin
			dec_op <= cls.op;
			dec_form <= cls.form;
			grp_r <= cls.grp;
			// short register forms always act on a word register
			if (cls.form == aod_form_short_reg) begin
				dec_w <= 1'b1;
			end else if (cls.form == aod_form_single || cls.form == aod_form_prefix) begin
				dec_w <= 1'b0;
			end else begin
				dec_w <= q_byte[AOD_W_BIT];
			end
			dec_d <= (cls.form == aod_form_rm_reg) && q_byte[AOD_DS_BIT];
			dec_s <= (cls.form == aod_form_rm_imm) && q_byte[AOD_DS_BIT];
			dec_mod <= AOD_MOD_REG;
			dec_reg <= (cls.form == aod_form_short_reg) ? q_byte[2:0] : 3'h0;
			dec_rm <= 3'h0;
			dec_mem <= 1'b0;
			disp_two <= 1'b0;
		end else if (take && (state == aod_st_modrm)) begin
			dec_op <= group_op(grp_r, in_reg, dec_op);
			dec_mod <= in_mod;
			dec_reg <= in_reg;
			dec_rm <= in_rm;
			dec_mem <= (in_mod != AOD_MOD_REG);
			disp_two <= (in_mod != AOD_MOD_DISP8);
		end
	end

	// displacement and immediate bytes, low byte first
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dec_disp <= 16'h0000;
			dec_imm <= 16'h0000;
		end else if (take) begin
			case (state)
				aod_st_opcode: begin
					dec_disp <= 16'h0000;
					dec_imm <= 16'h0000;
				end
				aod_st_disp_lo: dec_disp <= {{8{q_byte[7]}}, q_byte};
				aod_st_disp_hi: dec_disp[15:8] <= q_byte;
				aod_st_imm_lo: begin
					if (dec_w && dec_s && (dec_form == aod_form_rm_imm)) begin
						dec_imm <= {{8{q_byte[7]}}, q_byte};
					end else begin
						dec_imm <= {8'h00, q_byte};
					end
				end
				aod_st_imm_hi: dec_imm[15:8] <= q_byte;
				default: dec_imm <= dec_imm;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dec_len <= '0;
		end else if (take) begin
			dec_len <= (state == aod_st_opcode) ? 3'h1 : dec_len + 3'h1;
		end
	end

	// a prefix stays attached until the instruction it qualifies has left
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			seg_hold <= aod_seg_none;
		end else if (take && (state == aod_st_opcode) && (cls.form == aod_form_prefix)) begin
			seg_hold <= cls.seg;
		end else if (dec_valid && dec_ready && (dec_form != aod_form_prefix)) begin
			seg_hold <= aod_seg_none;
		end
	end

	// bus width is sampled once per instruction, at the finish step
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dec_clk_min <= '0;
			dec_clk_max <= '0;
			dec_seg <= aod_seg_none;
			dec_unsupported <= 1'b0;
		end else if (state == aod_st_finish) begin
			dec_clk_min <= next_clk.lo;
			dec_clk_max <= next_clk.hi;
			dec_seg <= seg_hold;
			dec_unsupported <= (dec_op == aod_op_other);
		end
	end
endmodule

/* tb/aod_decoder_properties.sv */
// port checker of the arithmetic opcode decoder
`timescale 1ns/1ps
module aod_properties
	import aod_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// watched ports
	input wire logic narrow_bus,
	input wire logic dec_valid,
	input wire aod_pkg::aod_op_t dec_op,
	input wire aod_pkg::aod_form_t dec_form,
	input wire logic dec_w,
	input wire logic dec_mem,
	input wire logic [aod_pkg::AOD_LEN_W-1:0] dec_len,
	input wire logic [aod_pkg::AOD_CLK_W-1:0] dec_clk_min,
	input wire logic [aod_pkg::AOD_CLK_W-1:0] dec_clk_max
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	sequence s_out(aod_op_t op);
		dec_valid && dec_op == op;
	endsequence
	property p_pfx;
		s_out(aod_op_segment_override) |-> dec_clk_max == 6'h02 && dec_len == 3'h1;
	endproperty
	property p_ubcd_add;
		s_out(aod_op_unpacked_bcd_adjust_after_addition) |-> dec_clk_min == 6'h08;
	endproperty
	property p_pdec;
		dec_valid && (dec_op == aod_op_packed_decimal_adjust_after_addition ||
			dec_op == aod_op_packed_decimal_adjust_after_subtraction) |-> dec_clk_max == 6'h04;
	endproperty
	property p_ubcd_sub;
		s_out(aod_op_unpacked_bcd_adjust_after_subtraction) |-> dec_clk_max == 6'h07;
	endproperty
	// memory word figure already includes the word cost, so no narrow extra
	property p_mult;
		s_out(aod_op_unsigned_multiply) |-> {dec_clk_min, dec_clk_max} == (dec_mem ?
			(dec_w ? {6'h29, 6'h2B} : {6'h20, 6'h22}) : (dec_w ? {6'h23, 6'h25} : {6'h1A, 6'h1C}));
	endproperty
	property p_cmpi;
		s_out(aod_op_comparison) ##0 dec_form == aod_form_rm_imm |-> dec_clk_max ==
			(dec_mem ? 6'h0A + (narrow_bus && dec_w ? 6'h04 : 6'h00) : 6'h03);
	endproperty
	property p_neg;
		s_out(aod_op_twos_complement_negation) |-> dec_clk_min ==
			(dec_mem ? 6'h0A + (narrow_bus && dec_w ? 6'h04 : 6'h00) : 6'h03);
	endproperty
	property p_acc;
		dec_valid && dec_form == aod_form_acc_imm |->
			dec_clk_max == (dec_w ? 6'h04 : 6'h03) && dec_len == (dec_w ? 3'h3 : 3'h2);
	endproperty
	property p_short;
		dec_valid && dec_form == aod_form_short_reg |-> dec_clk_max == 6'h03 && dec_len == 3'h1;
	endproperty
	a_pfx: assert property (p_pfx) else $error("prefix descriptor wrong");
	a_ubcd_add: assert property (p_ubcd_add) else $error("adjust add count wrong");
	a_pdec: assert property (p_pdec) else $error("packed adjust count wrong");
	a_ubcd_sub: assert property (p_ubcd_sub) else $error("adjust sub count wrong");
	a_mult: assert property (p_mult) else $error("multiply range wrong");
	a_cmpi: assert property (p_cmpi) else $error("immediate compare count wrong");
	a_neg: assert property (p_neg) else $error("negation count wrong");
	a_acc: assert property (p_acc) else $error("accumulator form wrong");
	a_short: assert property (p_short) else $error("short form wrong");
endmodule
bind aod_decoder aod_properties chk_u (.mclk(mclk), .nrst(nrst), .narrow_bus(narrow_bus),
	.dec_valid(dec_valid), .dec_op(dec_op), .dec_form(dec_form), .dec_w(dec_w),
	.dec_mem(dec_mem), .dec_len(dec_len), .dec_clk_min(dec_clk_min), .dec_clk_max(dec_clk_max));

/* tb/tb_aod_decoder.sv */
// self-checking bench of the arithmetic opcode decoder
`timescale 1ns/1ps
module tb_aod_decoder;
	import aod_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic narrow_bus = 1'b0;
	logic [7:0] q_byte = 8'h00;
	logic q_valid = 1'b0;
	logic dec_ready = 1'b0;
	logic q_ready, dec_valid, wide, dec_d, dec_s, dec_unsupported;
	logic [1:0] dec_mod;
	logic [2:0] dec_reg, dec_rm;
	logic [2:0] subs[5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
	aod_op_t dec_op;
	aod_seg_t dec_seg, e_seg, pend, own;
	logic [15:0] dec_imm, dec_disp, e_disp, e_op, e_len, e_min, e_max, e_imm;
	logic [AOD_LEN_W-1:0] dec_len;
	logic [AOD_CLK_W-1:0] dec_clk_min, dec_clk_max;
	logic [7:0] bq[$];
	logic [7:0] tbl[8] = '{8'h2E, 8'h36, 8'h3E, 8'h26, 8'h37, 8'h27, 8'h3F, 8'h2F};
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int dl;
	aod_decoder dut_u (.mclk(mclk), .nrst(nrst), .narrow_bus(narrow_bus), .q_byte(q_byte),
		.q_valid(q_valid), .q_ready(q_ready), .dec_valid(dec_valid), .dec_ready(dec_ready),
		.dec_op(dec_op), .dec_form(), .dec_seg(dec_seg), .dec_w(), .dec_d(dec_d), .dec_s(dec_s),
		.dec_mod(dec_mod), .dec_reg(dec_reg), .dec_rm(dec_rm), .dec_mem(), .dec_disp(dec_disp),
		.dec_imm(dec_imm), .dec_len(dec_len), .dec_clk_min(dec_clk_min),
		.dec_clk_max(dec_clk_max), .dec_unsupported(dec_unsupported));
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			end_of_test();
		end
	end
	task end_of_test;
		$display("mismatches %0d compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task step;
		@(posedge mclk);
		#2;
	endtask
	function automatic logic [15:0] aop(input logic [2:0] r);
		case (r)
			3'h0: return 16'(aod_op_addition);
			3'h2: return 16'(aod_op_add_with_carry);
			3'h3: return 16'(aod_op_subtraction_with_borrow);
			3'h5: return 16'(aod_op_subtraction);
			default: return 16'(aod_op_comparison);
		endcase
	endfunction
	function automatic logic [15:0] rmc(input logic m, input logic [15:0] mv, input logic [15:0] rv);
		return m ? mv + (wide ? 16'h4 : 16'h0) : rv;
	endfunction
	task setx(input logic [15:0] op, input int len, input logic [15:0] mn, input logic [15:0] mx);
		e_op = op;
		e_len = 16'(len);
		e_min = mn;
		e_max = mx;
	endtask
	task calc(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] im);
		logic m;
		logic [2:0] r;
		m = b1[7:6] != 2'h3;
		r = b1[5:3];
		wide = narrow_bus && m && b0[0];
		dl = b1[7:6] == 2'h1 ? 1 : (b1[7:6] == 2'h2 || b1 ==? 8'b00???110) ? 2 : 0;
		e_imm = 16'h0000;
		own = b0 == 8'h2E ? aod_seg_code : b0 == 8'h36 ? aod_seg_stack :
			b0 == 8'h3E ? aod_seg_data : aod_seg_extra;
		if (b0 inside {8'h2E, 8'h36, 8'h3E, 8'h26}) setx(16'(aod_op_segment_override), 1, 2, 2);
		else if (b0 == 8'h37) setx(16'(aod_op_unpacked_bcd_adjust_after_addition), 1, 8, 8);
		else if (b0 == 8'h27) setx(16'(aod_op_packed_decimal_adjust_after_addition), 1, 4, 4);
		else if (b0 == 8'h3F) setx(16'(aod_op_unpacked_bcd_adjust_after_subtraction), 1, 7, 7);
		else if (b0 == 8'h2F) setx(16'(aod_op_packed_decimal_adjust_after_subtraction), 1, 4, 4);
		else if (b0[7:4] == 4'h4)
			setx(b0[3] ? 16'(aod_op_decrement_op) : 16'(aod_op_increment_op), 1, 3, 3);
		else if (b0[7:6] == 2'h0 && !b0[2])
			setx(aop(b0[5:3]), 2 + dl, rmc(m, 10, 3), rmc(m, 10, 3));
		else if (b0[7:6] == 2'h0) begin
			setx(aop(b0[5:3]), 2 + b0[0], 3 + b0[0], 3 + b0[0]);
			e_imm = b0[0] ? im : {8'h00, im[7:0]};
		end else if (b0[7:2] == 6'b100000) begin
			setx(aop(r), 3 + dl + (b0[1:0] == 2'h1), r == 3'h7 ? rmc(m, 10, 3) : rmc(m, 16, 4), 0);
			e_max = e_min;
			e_imm = b0[1:0] == 2'h1 ? im : {{8{&b0[1:0] & im[7]}}, im[7:0]};
		end else if (b0[7:1] == 7'h7B && r == 3'h3)
			setx(16'(aod_op_twos_complement_negation), 2 + dl, rmc(m, 10, 3), rmc(m, 10, 3));
		else if (b0[7:1] == 7'h7B) begin
			setx(16'(aod_op_unsigned_multiply), 2 + dl, 0, 0);
			{e_min, e_max} = m ? (b0[0] ? {16'h29, 16'h2B} : {16'h20, 16'h22}) :
				(b0[0] ? {16'h23, 16'h25} : {16'h1A, 16'h1C});
		end else
			setx(r[0] ? 16'(aod_op_decrement_op) : 16'(aod_op_increment_op), 2 + dl,
				rmc(m, 15, 3), rmc(m, 15, 3));
	endtask
	// hm: the form carries a mod r/m byte; immediate bytes fill out the length
	task run(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] im, input logic hm);
		int n;
		logic [10:0] e_fld;
		calc(b0, b1, im);
		e_seg = e_op == 16'(aod_op_segment_override) ? own : pend;
		bq = {b0};
		e_disp = 16'h0000;
		e_fld = {5'h03, (b0[7:4] == 4'h4 ? b0[2:0] : 3'h0), 3'h0};
		if (hm) begin
			bq.push_back(b1);
			repeat (dl) bq.push_back(8'($urandom));
			e_disp = dl == 2 ? {bq[3], bq[2]} : dl == 1 ? {{8{bq[2][7]}}, bq[2]} : 16'h0000;
			e_fld = {1'b0, b0[7:6] == 2'h0 && b0[1], b0[7:2] == 6'b100000 && b0[1], b1};
		end
		n = int'(e_len) - bq.size();
		for (int i = 0; i < n; i++) bq.push_back(im[8*i+:8]);
		foreach (bq[j]) begin
			q_byte = bq[j];
			q_valid = 1'b1;
			while (q_ready !== 1'b1) step();
			step();
		end
		q_valid = 1'b0;
		while (dec_valid !== 1'b1) step();
		repeat ($urandom_range(0, 2)) step();
		chk(16'(dec_op), e_op);
		chk(16'(dec_len), e_len);
		chk(16'(dec_clk_min), e_min);
		chk(16'(dec_clk_max), e_max);
		chk(16'(dec_seg), 16'(e_seg));
		chk(dec_imm, e_imm);
		chk(dec_disp, e_disp);
		chk(16'({dec_unsupported, dec_d, dec_s, dec_mod, dec_reg, dec_rm}), 16'(e_fld));
		pend = e_op == 16'(aod_op_segment_override) ? own : aod_seg_none;
		dec_ready = 1'b1;
		step();
		dec_ready = 1'b0;
	endtask
	initial begin
		logic [2:0] s;
		logic [7:0] b0, b1;
		pend = aod_seg_none;
		void'($urandom(32'hF05A2620));
		repeat (12) @(posedge mclk);
		#2;
		nrst = 1'b1;
		// consecutive prefixes: the last one wins on the next instruction
		foreach (tbl[i]) run(tbl[i], 8'h00, 16'h0000, 1'b0);
		narrow_bus = 1'b1;
		run(8'h83, 8'h06, 16'h0080, 1'b1);
		run(8'h81, 8'h7E, 16'hBEEF, 1'b1);
		run(8'hF7, 8'h26, 16'h0000, 1'b1);
		run(8'h05, 8'h00, 16'h1234, 1'b0);
		for (int k = 0; k < 300; k++) begin
			narrow_bus = 1'($urandom);
			s = subs[$urandom_range(0, 4)];
			b1 = 8'($urandom);
			case ($urandom_range(0, 6))
				0: b0 = {2'b00, s, 1'b0, 2'($urandom)};
				1: b0 = {2'b00, s, 2'b10, 1'($urandom)};
				2: begin
					b0 = {6'b100000, 2'($urandom)};
					b1[5:3] = s;
				end
				3: begin
					b0 = {7'h7B, 1'($urandom)};
					b1[5:3] = 3'h3 + 3'($urandom_range(0, 1));
				end
				4: begin
					b0 = {7'h7F, 1'($urandom)};
					b1[5:3] = 3'($urandom_range(0, 1));
				end
				5: b0 = {4'h4, 4'($urandom)};
				default: b0 = tbl[$urandom_range(0, 7)];
			endcase
			run(b0, b1, 16'($urandom), b0[7] || (b0[7:6] == 2'h0 && !b0[2]));
		end
		end_of_test();
	end
endmodule
